//--- src/sfr_pkg.sv
package sfr_pkg;
	localparam logic [7:0] OP_READ      = 8'h03;
	localparam logic [7:0] OP_FAST      = 8'h0b;
	localparam logic [7:0] OP_DUAL_OUT  = 8'h3b;
	localparam logic [7:0] OP_QUAD_OUT  = 8'h6b;
	localparam logic [7:0] OP_DUAL_IO   = 8'hbb;
	localparam logic [7:0] OP_QUAD_IO   = 8'heb;
	localparam logic [7:0] OP_WRAP      = 8'h77;
	localparam logic [7:0] OP_SR_WRITE  = 8'h01;
	localparam logic [5:0] OPCODE_BITS  = 6'h08;
	localparam logic [5:0] ADDR_BITS    = 6'h18;
	localparam logic [5:0] MODE_BITS    = 6'h08;
	localparam logic [5:0] DUMMY_FAST   = 6'h08;
	localparam logic [5:0] DUMMY_IO     = 6'h04;
	localparam logic [5:0] WRAP_BITS    = 6'h20;
	localparam logic [5:0] SR1_BITS     = 6'h08;
	localparam logic [5:0] SR2_BITS     = 6'h10;
	localparam logic [5:0] CNT_MAX      = 6'h3f;
	localparam logic [3:0] BYTE_BITS    = 4'h8;
	localparam int         WRAP_DIS_POS = 4;
	localparam int         WRAP_MSB_POS = 6;
	localparam logic [2:0] WRAP_RESET   = 3'h1;
	localparam logic [7:0] WRAP_MASK8   = 8'h07;
	localparam int         BUF_DEPTH    = 2;

	typedef enum {
		ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_WRAP, ST_SR_DATA, ST_IGNORE
	} sfr_state_e;

	typedef struct packed {
		logic       wr1;
		logic       wr2;
		logic [7:0] sr1;
		logic [7:0] sr2;
	} sfr_sr_write_s;

	typedef struct packed {
		logic [3:0] lane_out;
		logic [3:0] lane_oe;
	} sfr_lanes_s;
endpackage : sfr_pkg

//--- src/sfr_read_unit.sv
`timescale 1ns/100ps
module sfr_read_unit (
	input  wire logic                   mclk,
	input  wire logic                   reset,
	input  wire logic                   ce,
	input  wire logic                   cs_n,
	input  wire logic                   sclk,
	input  wire logic [3:0]             lane_in,
	output sfr_pkg::sfr_lanes_s         lanes,
	input  wire logic                   busy,
	input  wire logic                   four_wire_enable,
	output logic      [23:0]            mem_addr,
	output logic                        mem_req,
	input  wire logic                   mem_valid,
	input  wire logic [7:0]             mem_data,
	output logic                        mem_ready,
	output sfr_pkg::sfr_sr_write_s      sr_write,
	output logic      [2:0]             wrap_setting
);
	logic [5:0] sync1_ff, sync2_ff;
	logic       sclk_d_ff, cs_d_ff;
	logic       cs_s, sclk_s, sclk_rise, sclk_fall, cs_rise;
	logic [3:0] lane_s;
	// pins cross from the host's clock; only sync2_ff is looked at
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			sync1_ff  <= 6'h3f;
			sync2_ff  <= 6'h3f;
			sclk_d_ff <= 1'b1;
			cs_d_ff   <= 1'b1;
		end else if (ce) begin
			sync1_ff  <= {cs_n, sclk, lane_in};
			sync2_ff  <= sync1_ff;
			sclk_d_ff <= sync2_ff[4];
			cs_d_ff   <= sync2_ff[5];
		end
	end
	assign cs_s      = sync2_ff[5];
	assign sclk_s    = sync2_ff[4];
	assign lane_s    = sync2_ff[3:0];
	assign sclk_rise = sclk_s & ~sclk_d_ff;
	assign sclk_fall = ~sclk_s & sclk_d_ff;
	assign cs_rise   = cs_s & ~cs_d_ff;
	function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] l,
						 input logic [2:0] w);
		unique case (w)
			3'h2:    shift_in = {sh[21:0], l[1:0]};
			3'h4:    shift_in = {sh[19:0], l[3:0]};
			default: shift_in = {sh[22:0], l[0]};
		endcase
	endfunction : shift_in
	function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wrap_on,
						  input logic [2:0] ws);
		logic [7:0] m;
		logic [7:0] inc;
		m   = wrap_mask_of(ws);
		inc = a[7:0] + 8'h01;
		if (wrap_on)
			next_addr = {a[23:8], (a[7:0] & ~m) | (inc & m)};
		else
			next_addr = a + 24'h000001;
	endfunction : next_addr
	function automatic logic [7:0] wrap_mask_of(input logic [2:0] ws);
		wrap_mask_of = (sfr_pkg::WRAP_MASK8 << ws[2:1]) | sfr_pkg::WRAP_MASK8;
	endfunction : wrap_mask_of
	// two-entry buffer between memory and the output shifter
	logic [7:0] buf_ff [sfr_pkg::BUF_DEPTH];
	logic       wptr_ff, rptr_ff, nxt_wptr, nxt_rptr;
	logic [1:0] bcnt_ff, nxt_bcnt;
	logic       push, pop, flush, buf_valid;
	assign buf_valid = (bcnt_ff != 2'h0);
	assign mem_ready = mem_req & (bcnt_ff != 2'(sfr_pkg::BUF_DEPTH));
	assign push      = mem_valid & mem_ready;

	always_comb begin
		nxt_wptr = wptr_ff;
		nxt_rptr = rptr_ff;
		nxt_bcnt = bcnt_ff;
		if (flush) begin
			nxt_wptr = 1'b0;
			nxt_rptr = 1'b0;
			nxt_bcnt = 2'h0;
		end else begin
			if (push)
				nxt_wptr = ~wptr_ff;
			if (pop)
				nxt_rptr = ~rptr_ff;
			nxt_bcnt = bcnt_ff + 2'(push) - 2'(pop);
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wptr_ff <= 1'b0;
			rptr_ff <= 1'b0;
			bcnt_ff <= 2'h0;
			buf_ff  <= '{default: 8'h00};
		end else if (ce) begin
			wptr_ff <= nxt_wptr;
			rptr_ff <= nxt_rptr;
			bcnt_ff <= nxt_bcnt;
			if (push && !flush)
				buf_ff[wptr_ff] <= mem_data;
		end
	end

	// instruction sequencer
	sfr_pkg::sfr_state_e   state_ff, nxt_state;
	logic [7:0]            op_ff, nxt_op, op_in;
	logic [5:0]            cnt_ff, nxt_cnt, cnt_inc;
	logic [23:0]           sh_ff, nxt_sh;
	logic [2:0]            wid_ff, nxt_wid, dwid_ff, nxt_dwid;
	logic [5:0]            dummy_ff, nxt_dummy;
	logic [7:0]            obyte_ff, nxt_obyte, ob;
	logic [3:0]            obits_ff, nxt_obits;
	logic [23:0]           addr_ff, nxt_addr;
	logic                  req_ff, nxt_req, wrap_on_ff, nxt_wrap_on;
	logic [2:0]            wrap_ff, nxt_wrap;
	sfr_pkg::sfr_lanes_s   lanes_ff, nxt_lanes;
	sfr_pkg::sfr_sr_write_s srw_ff, nxt_srw;

	assign cnt_inc = cnt_ff + 6'(wid_ff);
	assign op_in   = {sh_ff[6:0], lane_s[0]};

	always_comb begin
		nxt_state   = state_ff;
		nxt_op      = op_ff;
		nxt_cnt     = cnt_ff;
		nxt_sh      = sh_ff;
		nxt_wid     = wid_ff;
		nxt_dwid    = dwid_ff;
		nxt_dummy   = dummy_ff;
		nxt_obyte   = obyte_ff;
		nxt_obits   = obits_ff;
		nxt_addr    = addr_ff;
		nxt_req     = req_ff;
		nxt_wrap_on = wrap_on_ff;
		nxt_wrap    = wrap_ff;
		nxt_lanes   = lanes_ff;
		nxt_srw     = '0;
		pop         = 1'b0;
		flush       = 1'b0;
		ob          = 8'h00;
		if (push)
			nxt_addr = next_addr(addr_ff, wrap_on_ff, wrap_ff);
		if (cs_s) begin
			// partial instructions are dropped; status writes commit only at 8 or 16 bits
			if (cs_rise && state_ff == sfr_pkg::ST_SR_DATA) begin
				if (cnt_ff == sfr_pkg::SR1_BITS) begin
					nxt_srw.wr1 = 1'b1;
					nxt_srw.sr1 = sh_ff[7:0];
				end else if (cnt_ff == sfr_pkg::SR2_BITS) begin
					nxt_srw = {1'b1, 1'b1, sh_ff[15:8], sh_ff[7:0]};
				end
			end
			nxt_state = sfr_pkg::ST_OPCODE;
			nxt_cnt   = 6'h00;
			nxt_wid   = 3'h1;
			nxt_req   = 1'b0;
			nxt_obits = 4'h0;
			nxt_lanes = '0;
			flush     = 1'b1;
		end else if (sclk_rise) begin
			unique case (state_ff)
				sfr_pkg::ST_OPCODE: begin
					nxt_sh  = shift_in(sh_ff, lane_s, 3'h1);
					nxt_cnt = cnt_ff + 6'h01;
					if (nxt_cnt == sfr_pkg::OPCODE_BITS) begin
						nxt_op      = op_in;
						nxt_cnt     = 6'h00;
						nxt_state   = sfr_pkg::ST_ADDR;
						nxt_dummy   = sfr_pkg::DUMMY_FAST;
						nxt_wrap_on = 1'b0;
						unique case (op_in)
							sfr_pkg::OP_READ:     nxt_dwid = 3'h1;
							sfr_pkg::OP_FAST:     nxt_dwid = 3'h1;
							sfr_pkg::OP_DUAL_OUT: nxt_dwid = 3'h2;
							sfr_pkg::OP_QUAD_OUT: nxt_dwid = 3'h4;
							sfr_pkg::OP_DUAL_IO: begin
								nxt_dwid  = 3'h2;
								nxt_wid   = 3'h2;
								nxt_dummy = sfr_pkg::DUMMY_IO;
							end
							sfr_pkg::OP_QUAD_IO: begin
								nxt_dwid    = 3'h4;
								nxt_wid     = 3'h4;
								nxt_dummy   = sfr_pkg::DUMMY_IO;
								nxt_wrap_on = ~wrap_ff[0];
							end
							sfr_pkg::OP_WRAP: begin
								nxt_wid   = 3'h4;
								nxt_state = sfr_pkg::ST_WRAP;
							end
							sfr_pkg::OP_SR_WRITE: nxt_state = sfr_pkg::ST_SR_DATA;
							default:              nxt_state = sfr_pkg::ST_IGNORE;
						endcase
						// reads are dropped while a write cycle runs
						if (nxt_state == sfr_pkg::ST_ADDR && busy)
							nxt_state = sfr_pkg::ST_IGNORE;
						if ((op_in == sfr_pkg::OP_QUAD_OUT || op_in == sfr_pkg::OP_QUAD_IO)
						    && !four_wire_enable)
							nxt_state = sfr_pkg::ST_IGNORE;
					end
				end
				sfr_pkg::ST_ADDR: begin
					nxt_sh  = shift_in(sh_ff, lane_s, wid_ff);
					nxt_cnt = cnt_inc;
					if (cnt_inc == sfr_pkg::ADDR_BITS) begin
						nxt_cnt  = 6'h00;
						nxt_addr = nxt_sh;
						nxt_req  = 1'b1;
						flush    = 1'b1;
						if (op_ff == sfr_pkg::OP_READ)
							nxt_state = sfr_pkg::ST_DATA;
						else if (op_ff == sfr_pkg::OP_DUAL_IO || op_ff == sfr_pkg::OP_QUAD_IO)
							nxt_state = sfr_pkg::ST_MODE;
						else
							nxt_state = sfr_pkg::ST_DUMMY;
					end
				end
				sfr_pkg::ST_MODE: begin
					// mode bits are taken but continuous read is not offered
					nxt_cnt = cnt_inc;
					if (cnt_inc == sfr_pkg::MODE_BITS) begin
						nxt_cnt   = 6'h00;
						nxt_state = sfr_pkg::ST_DUMMY;
					end
				end
				sfr_pkg::ST_DUMMY: begin
					nxt_cnt = cnt_ff + 6'h01;
					if (nxt_cnt == dummy_ff)
						nxt_state = sfr_pkg::ST_DATA;
				end
				sfr_pkg::ST_WRAP: begin
					nxt_sh  = shift_in(sh_ff, lane_s, wid_ff);
					nxt_cnt = cnt_inc;
					if (cnt_inc == sfr_pkg::WRAP_BITS) begin
						nxt_wrap  = nxt_sh[sfr_pkg::WRAP_MSB_POS:sfr_pkg::WRAP_DIS_POS];
						nxt_state = sfr_pkg::ST_IGNORE;
					end
				end
				sfr_pkg::ST_SR_DATA: begin
					nxt_sh = shift_in(sh_ff, lane_s, 3'h1);
					if (cnt_ff != sfr_pkg::CNT_MAX)
						nxt_cnt = cnt_ff + 6'h01;
				end
				sfr_pkg::ST_DATA, sfr_pkg::ST_IGNORE: begin
				end
			endcase
		end else if (sclk_fall && state_ff == sfr_pkg::ST_DATA) begin
			// an empty buffer here is an underrun: lanes hold their last value
			ob = obyte_ff;
			if (obits_ff == 4'h0 && buf_valid) begin
				ob        = buf_ff[rptr_ff];
				pop       = 1'b1;
				nxt_obits = sfr_pkg::BYTE_BITS;
			end
			if (obits_ff != 4'h0 || buf_valid) begin
				unique case (dwid_ff)
					3'h4:    nxt_lanes = {ob[7:4], 4'hf};
					3'h2:    nxt_lanes = {2'b00, ob[7:6], 4'h3};
					default: nxt_lanes = {2'b00, ob[7], 1'b0, 4'h2};
				endcase
				nxt_obyte = ob << dwid_ff;
				nxt_obits = nxt_obits - 4'(dwid_ff);
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_ff   <= sfr_pkg::ST_OPCODE;
			op_ff      <= 8'h00;
			cnt_ff     <= 6'h00;
			sh_ff      <= 24'h000000;
			wid_ff     <= 3'h1;
			dwid_ff    <= 3'h1;
			dummy_ff   <= 6'h00;
			obyte_ff   <= 8'h00;
			obits_ff   <= 4'h0;
			addr_ff    <= 24'h000000;
			req_ff     <= 1'b0;
			wrap_on_ff <= 1'b0;
			wrap_ff    <= sfr_pkg::WRAP_RESET;
			lanes_ff   <= '0;
			srw_ff     <= '0;
		end else if (ce) begin
			state_ff   <= nxt_state;
			op_ff      <= nxt_op;
			cnt_ff     <= nxt_cnt;
			sh_ff      <= nxt_sh;
			wid_ff     <= nxt_wid;
			dwid_ff    <= nxt_dwid;
			dummy_ff   <= nxt_dummy;
			obyte_ff   <= nxt_obyte;
			obits_ff   <= nxt_obits;
			addr_ff    <= nxt_addr;
			req_ff     <= nxt_req;
			wrap_on_ff <= nxt_wrap_on;
			wrap_ff    <= nxt_wrap;
			lanes_ff   <= nxt_lanes;
			srw_ff     <= nxt_srw;
		end
	end

	assign lanes        = lanes_ff;
	assign mem_addr     = addr_ff;
	assign mem_req      = req_ff;
	assign sr_write     = srw_ff;
	assign wrap_setting = wrap_ff;
endmodule : sfr_read_unit

//--- bench/sfr_read_unit_checker.sv
`timescale 1ns/100ps
module sfr_read_unit_checker (
	input wire logic             mclk,
	input wire logic             reset,
	input wire logic             cs_n,
	input wire logic             sclk,
	input sfr_pkg::sfr_lanes_s   lanes,
	input wire logic             busy,
	input wire logic             four_wire_enable,
	input wire logic [23:0]      mem_addr,
	input wire logic             mem_req,
	input wire logic             mem_valid,
	input wire logic             mem_ready,
	input sfr_pkg::sfr_sr_write_s sr_write,
	input wire logic [2:0]       wrap_setting
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);
	property p_wrap_rst;
		$fell(reset) |-> wrap_setting == 3'h1;
	endproperty
	a_wrap_rst: assert property (p_wrap_rst) else $error("wrap on after reset");
	property p_idle;
		cs_n [*5] |-> lanes.lane_oe == 4'h0 && !mem_req;
	endproperty
	a_idle: assert property (p_idle) else $error("active while deselected");
	property p_drive;
		$rose(lanes.lane_oe != 4'h0) |-> mem_req;
	endproperty
	a_drive: assert property (p_drive) else $error("drive outside data phase");
	property p_sr_pair;
		sr_write.wr2 |-> sr_write.wr1;
	endproperty
	a_sr_pair: assert property (p_sr_pair) else $error("second write alone");
	property p_sr_cs;
		sr_write.wr1 |-> cs_n ##1 !sr_write.wr1;
	endproperty
	a_sr_cs: assert property (p_sr_cs) else $error("status pulse misplaced");
	property p_ready;
		mem_req && !(mem_valid && mem_ready) |=> $stable(mem_addr);
	endproperty
	a_ready: assert property (p_ready) else $error("address moved without a fetch");
	property p_step;
		mem_valid && mem_ready && wrap_setting[0] |=> mem_addr == $past(mem_addr) + 24'h1;
	endproperty
	a_step: assert property (p_step) else $error("address not advanced");
	property p_busy;
		$rose(mem_req) |-> !busy;
	endproperty
	a_busy: assert property (p_busy) else $error("read taken while busy");
	property p_quad;
		lanes.lane_oe == 4'hf |-> four_wire_enable;
	endproperty
	a_quad: assert property (p_quad) else $error("quad without enable");
	property p_fall;
		$changed(lanes.lane_out) && lanes.lane_oe != 4'h0 |-> !$past(sclk, 2);
	endproperty
	a_fall: assert property (p_fall) else $error("output moved off falling edge");
endmodule : sfr_read_unit_checker
bind sfr_read_unit sfr_read_unit_checker u_chk (.mclk, .reset, .cs_n, .sclk, .lanes, .busy,
	.four_wire_enable, .mem_addr, .mem_req, .mem_valid, .mem_ready, .sr_write, .wrap_setting);

//--- bench/sfr_host.sv
`timescale 1ns/100ps
module sfr_host (
	input wire logic           mclk,
	input sfr_pkg::sfr_lanes_s lanes,
	output logic               cs_n,
	output logic               sclk,
	output logic [3:0]         lane_in
);
	logic [3:0] drv_ff;
	logic [3:0] oe_ff;
	logic [7:0] rx_byte;
	event       rx_ev;
	// a released, undriven lane shows the inverse of its last level, never a stale copy
	assign lane_in = (drv_ff & oe_ff) | (lanes.lane_out & lanes.lane_oe)
		| (~drv_ff & ~oe_ff & ~lanes.lane_oe);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		drv_ff = 4'h0;
		oe_ff = 4'h0;
	end
	task automatic tick(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] got);
		drv_ff <= v;
		oe_ff <= oe;
		sclk <= 1'b0;
		repeat (4) @(posedge mclk);
		sclk <= 1'b1;
		@(posedge mclk);
		#1 got = lane_in;
		repeat (3) @(posedge mclk);
	endtask : tick
	// md 0 drives, 1 releases and ignores, 2 releases and collects bytes
	task automatic shift(input logic [63:0] d, input int n, input int w, input int md,
			output logic [63:0] q);
		logic [3:0] m;
		logic [3:0] g;
		m = 4'((1 << w) - 1);
		q = '0;
		for (int i = 0; i < n; i++) begin
			tick(d[63:60] >> (4 - w), md == 0 ? m : 4'h0, g);
			d = d << w;
			q = (q << w) | 64'(w == 1 ? {3'h0, g[1]} : g & m);
			if (md == 2 && (i + 1) * w % 8 == 0) begin
				rx_byte = q[7:0];
				-> rx_ev;
			end
		end
	endtask : shift
	task automatic sel();
		cs_n <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask : sel
	task automatic desel();
		sclk <= 1'b0;
		oe_ff <= 4'h0;
		repeat (4) @(posedge mclk);
		cs_n <= 1'b1;
		repeat (8) @(posedge mclk);
	endtask : desel
endmodule : sfr_host

//--- bench/sfr_read_unit_tb.sv
`timescale 1ns/100ps
module sfr_read_unit_tb;
	logic                   mclk;
	logic                   reset;
	logic                   cs_n;
	logic                   sclk;
	logic [3:0]             lane_in;
	sfr_pkg::sfr_lanes_s    lanes;
	logic                   busy;
	logic                   four_wire_enable;
	logic [23:0]            mem_addr;
	logic                   mem_req;
	logic                   mem_valid;
	logic [7:0]             mem_data;
	logic                   mem_ready;
	sfr_pkg::sfr_sr_write_s sr_write;
	logic [2:0]             wrap_setting;
	logic [2:0]             wexp;
	logic                   req_seen;
	int                     error_cnt;
	int                     checked;
	logic [7:0]             exp_q[$];
	logic [17:0]            sr_q[$];
	logic [7:0]             ops[6] = '{sfr_pkg::OP_READ, sfr_pkg::OP_FAST, sfr_pkg::OP_DUAL_OUT,
		sfr_pkg::OP_QUAD_OUT, sfr_pkg::OP_DUAL_IO, sfr_pkg::OP_QUAD_IO};
	int                     aws[6] = '{1, 1, 1, 1, 2, 4};
	int                     dms[6] = '{0, 8, 8, 8, 4, 4};
	int                     dws[6] = '{1, 1, 2, 4, 2, 4};
	sfr_read_unit u_dut (.mclk, .reset, .ce(1'b1), .cs_n, .sclk, .lane_in, .lanes, .busy,
		.four_wire_enable, .mem_addr, .mem_req, .mem_valid, .mem_data, .mem_ready, .sr_write,
		.wrap_setting);
	sfr_host u_host (.mclk, .lanes, .cs_n, .sclk, .lane_in);
	function automatic logic [7:0] mem_fn(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction : mem_fn
	assign mem_data = mem_fn(mem_addr);
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// stalls only once streaming, so the first byte is always on time
	always @(posedge mclk) mem_valid <= !mem_req || ($urandom_range(3) != 0);
	always @(posedge mclk) if (mem_req) req_seen <= 1'b1;
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp8
	task automatic cmp_sr(input logic [17:0] got, input logic [17:0] exp);
		checked++;
		if (!exp[16])
			got[7:0] = exp[7:0];
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_sr
	always @(u_host.rx_ev) cmp8(u_host.rx_byte, exp_q.pop_front());
	always @(negedge mclk)
		if (sr_write.wr1 === 1'b1) cmp_sr(sr_write, sr_q.pop_front());
	task automatic rd(input logic [7:0] op, input logic [23:0] a, input int aw, input int dm,
			input int dw, input logic ok);
		logic [63:0] q;
		logic [23:0] m;
		m = 24'hffffff;
		if (op == sfr_pkg::OP_QUAD_IO && !wexp[0])
			m = (24'h8 << wexp[2:1]) - 24'h1;
		for (int i = 0; i < 3; i++)
			if (ok)
				exp_q.push_back(mem_fn((a & ~m) | ((a + 24'(i)) & m)));
		u_host.sel();
		u_host.shift({op, 56'h0}, 8, 1, 0, q);
		u_host.shift({a, 8'hf0, 32'h0}, aw == 1 ? 24 : 32 / aw, aw, 0, q);
		u_host.shift('0, dm, 1, 1, q);
		u_host.shift('0, 24 / dw, dw, ok ? 2 : 1, q);
		u_host.desel();
	endtask : rd
	task automatic wrp(input logic [7:0] w);
		logic [63:0] q;
		u_host.sel();
		u_host.shift({sfr_pkg::OP_WRAP, 56'h0}, 8, 1, 0, q);
		u_host.shift({24'h0, w, 32'h0}, 8, 4, 0, q);
		u_host.desel();
		wexp = w[6:4];
		cmp8({5'h0, wrap_setting}, {5'h0, wexp});
	endtask : wrp
	task automatic sw(input int n, input logic [15:0] d);
		logic [63:0] q;
		u_host.sel();
		u_host.shift({sfr_pkg::OP_SR_WRITE, d, 40'h0}, 8 + n, 1, 0, q);
		u_host.desel();
	endtask : sw
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		#1_000_000;
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		logic [23:0] a;
		logic [15:0] d;
		void'($urandom(32'hc88dd2ae));
		reset = 1'b1;
		busy = 1'b0;
		four_wire_enable = 1'b1;
		mem_valid = 1'b0;
		req_seen = 1'b0;
		error_cnt = 0;
		checked = 0;
		wexp = 3'h1;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		cmp8({5'h0, wrap_setting}, 8'h01);
		cmp8(lanes, 8'h00);
		d = 16'($urandom);
		sr_q.push_back({2'b11, d});
		sw(16, d);
		sr_q.push_back({2'b10, d});
		sw(8, d);
		sw(12, d);
		for (int k = 0; k < 6; k++) begin
			a = {8'($urandom), 8'($urandom), 8'hfe};
			rd(ops[k], a, aws[k], dms[k], dws[k], 1'b1);
		end
		req_seen = 1'b0;
		four_wire_enable <= 1'b0;
		rd(sfr_pkg::OP_QUAD_OUT, a, 1, 8, 4, 1'b0);
		rd(sfr_pkg::OP_QUAD_IO, a, 4, 4, 4, 1'b0);
		rd(8'h5a, a, 1, 8, 1, 1'b0);
		four_wire_enable <= 1'b1;
		busy <= 1'b1;
		for (int k = 0; k < 6; k++)
			rd(ops[k], a, aws[k], dms[k], dws[k], 1'b0);
		busy <= 1'b0;
		cmp8({7'h0, req_seen}, 8'h00);
		for (int s = 0; s < 4; s++) begin
			wrp({1'($urandom), 2'(s), 1'b0, 4'($urandom)});
			a = {18'($urandom), 6'h3e};
			rd(sfr_pkg::OP_QUAD_IO, a, 4, 4, 4, 1'b1);
		end
		wrp(8'h1f);
		rd(sfr_pkg::OP_QUAD_IO, a, 4, 4, 4, 1'b1);
		wrp(8'h20);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		wexp = 3'h1;
		@(posedge mclk);
		cmp8({5'h0, wrap_setting}, 8'h01);
		cmp8(8'(exp_q.size() + sr_q.size()), 8'h00);
		tally_and_finish();
	end
endmodule : sfr_read_unit_tb
